//--- verilog/acf_top.sv
/*
 Converter configuration and sequencing: control registers, input routing,
 reference selection, conversion clock and a bit-serial approximation loop.
 Assumes a register master per the plain strobe port and an external
 comparator that answers within one system clock.
*/
`timescale 1ns/100ps
module acf_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmp_above,
  output logic [13:0] source_enable,
  output logic pos_ref_pin_sel,
  output logic neg_ref_pin_sel,
  output logic analog_powered,
  output logic sample_connect,
  output logic [9:0] dac_trial,
  output logic conversion_done_flag
);
  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [4:0] sel_q;
  logic trig_q;
  logic pwr_q;
  logic [7:0] ctrl1_q;
  logic [9:0] result_q;
  logic [9:0] trial_q;
  logic [4:0] half_q;
  logic busy_q;
  logic tick;
  logic done_evt;
  logic bit_evt;
  logic [3:0] bit_idx;
  acf_pkg::acf_route_t route;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic rd_res_lo;
  logic [2:0] clk_sel_q;
  logic [13:0] src_hit;

  assign route.input_select_field = sel_q;
  assign route.pos_ref_select = ctrl1_q[acf_pkg::POS_PREF];
  assign route.neg_ref_select = ctrl1_q[acf_pkg::POS_NREF];
  assign route.converter_power_on = pwr_q;

  // ----------------------------------------------------------------------
  // Register strobe decode
  // ----------------------------------------------------------------------
  assign wr_ctrl0 = reg_wr && reg_addr == acf_pkg::OFF_CTRL0;
  assign wr_ctrl1 = reg_wr && reg_addr == acf_pkg::OFF_CTRL1;
  assign rd_res_lo = reg_rd && reg_addr == acf_pkg::OFF_RES_LO;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= 5'h00;
      pwr_q <= 1'b0;
      ctrl1_q <= acf_pkg::CTRL1_RESET;
    end else if (wr_ctrl0) begin
      sel_q <= reg_wdata[acf_pkg::POS_SEL_LSB +: acf_pkg::SEL_W];
      pwr_q <= reg_wdata[acf_pkg::POS_POWER];
    end else if (wr_ctrl1) begin
      ctrl1_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger bit: completion clears it; a write of 1 needs power on
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trig_q <= 1'b0;
    end else if (wr_ctrl0) begin
      trig_q <= reg_wdata[acf_pkg::POS_TRIGGER] && reg_wdata[acf_pkg::POS_POWER];
    end else if (done_evt || !pwr_q) begin
      trig_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer: 23 half periods, bit decision every two
  // ----------------------------------------------------------------------
  // Clock code held for the whole conversion: a write in flight
  // would otherwise change the bit period half way through
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_sel_q <= 3'h0;
    end else if (!busy_q) begin
      clk_sel_q <= ctrl1_q[acf_pkg::POS_CLK_LSB +: acf_pkg::CLK_W];
    end
  end

  acf_tick u_tick (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(busy_q),
    .clk_sel(clk_sel_q),
    .tick(tick)
  );

  // Half 0..2 is the first 1.5 periods; then one bit per two halves
  assign bit_evt = busy_q && tick && half_q >= 5'h02 && half_q[0] == 1'b0
    && half_q < 5'(acf_pkg::HALF_PERIODS - 1);
  assign bit_idx = 4'(5'h0A - ((half_q - 5'h02) >> 1)) - 4'h1;
  assign done_evt = busy_q && tick
    && half_q == 5'(acf_pkg::HALF_PERIODS - 1);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      half_q <= 5'h00;
    end else if (!trig_q || done_evt) begin
      busy_q <= 1'b0;
      half_q <= 5'h00;
    end else begin
      busy_q <= 1'b1;
      if (tick) begin
        half_q <= half_q + 5'h01;
      end
    end
  end

  // Trial word: keep bit if input above trial, set next bit down
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trial_q <= 10'h000;
    end else if (!busy_q) begin
      trial_q <= 10'h200;
    end else if (bit_evt) begin
      trial_q[bit_idx] <= cmp_above;
      if (bit_idx != 4'h0) begin
        trial_q[bit_idx - 4'h1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      result_q <= 10'h000;
    end else if (done_evt) begin
      result_q <= trial_q;
    end
  end

  // Done flag: set wins over the software clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      conversion_done_flag <= 1'b0;
    end else if (done_evt) begin
      conversion_done_flag <= 1'b1;
    end else if (rd_res_lo) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Source decode: one select code per routed source
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < acf_pkg::NUM_SOURCES; g++) begin : g_src
    // Pins 0-4 and 8-13 in order, then the three internal sources
    localparam logic [4:0] CODE = (g < 5) ? 5'(g)
      : (g < 11) ? 5'(g + 3)
      : (g == 11) ? acf_pkg::SEL_TEMP
      : (g == 12) ? acf_pkg::SEL_DAC : acf_pkg::SEL_FIXED;
    assign src_hit[g] = route.converter_power_on
      && route.input_select_field == CODE;
  end

  // ----------------------------------------------------------------------
  // Analog routing outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      source_enable <= 14'h0000;
      pos_ref_pin_sel <= 1'b0;
      neg_ref_pin_sel <= 1'b0;
      analog_powered <= 1'b0;
      sample_connect <= 1'b0;
      dac_trial <= 10'h000;
    end else begin
      source_enable <= src_hit;
      pos_ref_pin_sel <= route.pos_ref_select;
      neg_ref_pin_sel <= route.neg_ref_select;
      analog_powered <= route.converter_power_on;
      // Hold capacitor is cut off from the input while converting
      sample_connect <= route.converter_power_on && !trig_q;
      dac_trial <= trial_q;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        acf_pkg::OFF_CTRL0: reg_rdata <= {1'b0, sel_q, trig_q, pwr_q};
        acf_pkg::OFF_CTRL1: reg_rdata <= ctrl1_q;
        acf_pkg::OFF_RES_HI: reg_rdata <= ctrl1_q[acf_pkg::POS_FMT]
          ? {6'h00, result_q[9:8]} : result_q[9:2];
        acf_pkg::OFF_RES_LO: reg_rdata <= ctrl1_q[acf_pkg::POS_FMT]
          ? result_q[7:0] : {result_q[1:0], 6'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : acf_top

//--- verilog/acf_pkg.sv
/*
 Package for the converter configuration block: register offsets, field
 layouts, reset values, clock-select codes and timing counts.
 Assumes a 10 MHz system clock and an 8-bit register port.
*/
package acf_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [1:0] OFF_CTRL0 = 2'h0;
  localparam logic [1:0] OFF_CTRL1 = 2'h1;
  localparam logic [1:0] OFF_RES_HI = 2'h2;
  localparam logic [1:0] OFF_RES_LO = 2'h3;

  localparam int POS_POWER = 0;
  localparam int POS_TRIGGER = 1;
  localparam int POS_SEL_LSB = 2;
  localparam int SEL_W = 5;
  localparam int POS_PREF = 0;
  localparam int POS_NREF = 2;
  localparam int POS_CLK_LSB = 4;
  localparam int CLK_W = 3;
  localparam int POS_FMT = 7;

  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Input select codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] SEL_TEMP = 5'h1D;
  localparam logic [4:0] SEL_DAC = 5'h1E;
  localparam logic [4:0] SEL_FIXED = 5'h1F;
  localparam int NUM_SOURCES = 14;

  // ----------------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------------
  localparam int RES_W = 10;
  localparam int HALF_PERIODS = 23;
  localparam int RC_PERIOD_NS = 1600;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RC_HALF_CYCLES = (RC_PERIOD_NS / 2) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ACF_DIV2 = 3'h0, ACF_DIV8 = 3'h1, ACF_DIV32 = 3'h2, ACF_RC = 3'h3,
    ACF_DIV4 = 3'h4, ACF_DIV16 = 3'h5, ACF_DIV64 = 3'h6, ACF_RC2 = 3'h7
  } acf_clk_sel_t;

  typedef struct packed {
    logic [4:0] input_select_field;
    logic pos_ref_select;
    logic neg_ref_select;
    logic converter_power_on;
  } acf_route_t;

endpackage : acf_pkg

//--- verilog/acf_tick.sv
/*
 Half-period tick divider for the bit-conversion clock.
 Assumes the select code is held stable during a conversion.
*/
`timescale 1ns/100ps
module acf_tick (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  output logic tick
);
  logic [5:0] cnt_q;
  logic [5:0] limit;

  always_comb begin
    case (clk_sel)
      3'h0: limit = 6'h00;
      3'h4: limit = 6'h01;
      3'h1: limit = 6'h03;
      3'h5: limit = 6'h07;
      3'h2: limit = 6'h0F;
      3'h6: limit = 6'h1F;
      default: limit = 6'(acf_pkg::RC_HALF_CYCLES - 1);
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 6'h00;
    end else if (!run || cnt_q >= limit) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  assign tick = run && (cnt_q >= limit);
endmodule : acf_tick

//--- verification/acf_chk.sv
/* Port checker for acf_top.
 Assumes a bind from the bench top and the plain strobe register port. */
`timescale 1ns/100ps
module acf_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [13:0] source_enable,
  input wire logic pos_ref_pin_sel,
  input wire logic neg_ref_pin_sel,
  input wire logic analog_powered,
  input wire logic sample_connect,
  input wire logic [9:0] dac_trial,
  input wire logic conversion_done_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic w0;
  logic w1;
  logic rlo;
  assign w0 = reg_wr && reg_addr == acf_pkg::OFF_CTRL0;
  assign w1 = reg_wr && reg_addr == acf_pkg::OFF_CTRL1;
  assign rlo = reg_rd && reg_addr == acf_pkg::OFF_RES_LO;
  // Shadow of what software last wrote
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      c0_q <= 8'h00;
      c1_q <= 8'h00;
    end else begin
      if (w0) c0_q <= reg_wdata;
      if (w1) c1_q <= reg_wdata;
    end
  end
  one_src_a: assert property ($onehot0(source_enable)) else $error("two sources");
  sel_route_a: assert property (analog_powered && !w0 && !$past(w0) |->
    source_enable[0] == (c0_q[6:2] == 5'h00)) else $error("bad route");
  pos_ref_a: assert property (!w1 && !$past(w1) |->
    pos_ref_pin_sel == c1_q[0]) else $error("bad pos ref");
  neg_ref_a: assert property (!w1 && !$past(w1) |->
    neg_ref_pin_sel == c1_q[2]) else $error("bad neg ref");
  power_track_a: assert property (!w0 && !$past(w0) |->
    analog_powered == c0_q[0]) else $error("bad power");
  conv_len_a: assert property ($fell(sample_connect) && analog_powered
    && c1_q[6:4] == 3'h0 |-> ##[20:26] $rose(conversion_done_flag)) else $error("bad length");
  msb_first_a: assert property ($fell(sample_connect) && analog_powered |->
    ##[0:4] dac_trial == 10'h200) else $error("msb not first");
  flag_clear_a: assert property ($fell(conversion_done_flag) |->
    $past(rlo) || $past(rlo, 2)) else $error("flag lost");
  hold_reconnect_a: assert property ($rose(conversion_done_flag) |->
    ##[0:2] sample_connect) else $error("no reconnect");
endmodule : acf_chk

//--- verification/acf_src_model.sv
/* Analog sources: a fixed level per routed source, compared to the trial.
 Assumes source_enable is one-hot or zero. */
`timescale 1ns/100ps
module acf_src_model (
  input wire logic sys_clk,
  input wire logic [13:0] source_enable,
  input wire logic [9:0] dac_trial,
  output logic cmp_above
);
  logic last_q = 1'b0;
  logic [9:0] lvl;
  // Every pin already input and analog; each source its own level
  always_comb begin
    lvl = 10'h000;
    for (int k = 0; k < 14; k++) begin
      if (source_enable[k]) lvl = 10'(k * 71 + 9);
    end
  end
  // Nothing routed: toggle, so a stale compare cannot look valid
  assign cmp_above = (|source_enable) ? (lvl >= dac_trial) : !last_q;
  always_ff @(posedge sys_clk) last_q <= cmp_above;
endmodule : acf_src_model

//--- verification/tb.sv
/* Bench for acf_top: reset values, routing table, conversions, abort.
 Assumes acf_src_model and acf_chk are compiled before it. */
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cmp_above;
  logic [13:0] source_enable;
  logic pos_ref_pin_sel, neg_ref_pin_sel, analog_powered, sample_connect;
  logic [9:0] dac_trial;
  logic conversion_done_flag;
  int failures = 0;
  int check_count = 0;
  // Rows: select code beside the source it routes (14 = none)
  logic [4:0] row_code [17] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h09,
    5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h1D, 5'h1E, 5'h1F, 5'h05, 5'h07, 5'h0E};
  int row_src [17] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 14, 14};
  always #50 sys_clk = ~sys_clk;
  acf_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_above(cmp_above), .source_enable(source_enable), .dac_trial(dac_trial),
    .pos_ref_pin_sel(pos_ref_pin_sel), .neg_ref_pin_sel(neg_ref_pin_sel),
    .analog_powered(analog_powered), .sample_connect(sample_connect),
    .conversion_done_flag(conversion_done_flag));
  acf_src_model u_src (.sys_clk(sys_clk), .source_enable(source_enable),
    .dac_trial(dac_trial), .cmp_above(cmp_above));
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t byte %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_en(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t route %h exp %h", $time, got, exp);
    end
  endtask : chk_en
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_reg(reg_rdata, exp);
  endtask : rd
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    #1_000_000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    int n;
    int h;
    logic [9:0] lv;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    for (int i = 0; i < 17; i++) begin
      wr(2'h0, {1'b0, row_code[i], 2'b01});
      repeat (3) @(posedge sys_clk);
      #1 chk_en(source_enable, row_src[i] < 14 ? 14'(1 << row_src[i]) : 14'h0);
    end
    $display("test routing done");
    // Seven clock codes plus the second RC code; both result formats
    for (int i = 0; i < 8; i++) begin
      h = (i % 4 == 3) ? 8 : 1 << (2 * (i % 4) + i / 4);
      lv = 10'((i + 6) * 71 + 9);
      wr(2'h1, {i[0], 3'(i), 1'b0, i[2], 1'b0, i[1]});
      wr(2'h0, {1'b0, row_code[i + 6], 2'b01});
      repeat (8) @(posedge sys_clk);
      wr(2'h0, {1'b0, row_code[i + 6], 2'b11});
      n = 0;
      while (conversion_done_flag !== 1'b1 && n < 2000) begin
        @(posedge sys_clk);
        #1 n++;
      end
      chk_reg(8'(n >= 23 * h && n <= 23 * h + 4), 8'h01);
      chk_reg({6'h00, neg_ref_pin_sel, pos_ref_pin_sel}, {6'h00, i[2], i[1]});
      rd(2'h0, {1'b0, row_code[i + 6], 2'b01});
      rd(2'h2, i[0] ? {6'h00, lv[9:8]} : lv[9:2]);
      rd(2'h3, i[0] ? lv[7:0] : {lv[1:0], 6'h00});
      repeat (2) @(posedge sys_clk);
      #1 chk_reg({7'h00, conversion_done_flag}, 8'h00);
    end
    wr(2'h2, 8'hFF);
    rd(2'h2, {6'h00, lv[9:8]});
    $display("test conversions done");
    // Abort mid-conversion on the second RC clock code; the trigger with power 0 is dropped
    wr(2'h0, 8'h03);
    repeat (20) @(posedge sys_clk);
    wr(2'h0, 8'h02);
    repeat (300) @(posedge sys_clk);
    #1 chk_reg({7'h00, conversion_done_flag}, 8'h00);
    rd(2'h0, 8'h00);
    wr(2'h0, 8'h05);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(2'h0, 8'h00);
    $display("test abort and reset done");
    end_sim();
  end
endmodule : tb
bind acf_top acf_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .source_enable(source_enable),
  .pos_ref_pin_sel(pos_ref_pin_sel), .neg_ref_pin_sel(neg_ref_pin_sel),
  .analog_powered(analog_powered), .sample_connect(sample_connect),
  .dac_trial(dac_trial), .conversion_done_flag(conversion_done_flag));
